// [pcs_map.svh]
// Constant map for the program counter and call stack
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
`define PCS_PC_W 9
`define PCS_LOW_W 8
`define PCS_LIT_W 8
`define PCS_STACK_DEPTH 2
`define PCS_PC_RESET 9'h1FF
`define PCS_PC_ZERO 9'h000
`define PCS_PC_ONE 9'h001
`define PCS_HIGH_BIT 8
`endif

// [pcs_pkg.sv]
// Types shared by the program counter and call stack
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_OP_STEP,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_LOW_WRITE,
    PCS_OP_RETURN
  } pcs_op_e;

  typedef struct packed {
    pcs_op_e op;
    logic [8:0] target;
    logic [7:0] literal;
  } pcs_cmd_s;
endpackage

// [pcs_ret_stack.sv]
// Two-level return stack
`include "pcs_map.svh"
module pcs_ret_stack #(
  parameter int ADDR_W = `PCS_PC_W
) (
  input wire logic sys_clk,
  input wire logic push,
  input wire logic pop,
  input wire logic [ADDR_W-1:0] push_addr,
  output logic [ADDR_W-1:0] top,
  output logic [ADDR_W-1:0] second
);
  // ========================================
  // Storage
  logic [ADDR_W-1:0] lvl_q [`PCS_STACK_DEPTH];
  logic [ADDR_W-1:0] lvl_d [`PCS_STACK_DEPTH];

  // Reset leaves contents alone on purpose
  always_comb begin
    lvl_d[0] = lvl_q[0];
    lvl_d[1] = lvl_q[1];
    if (push) begin
      lvl_d[1] = lvl_q[0];
      lvl_d[0] = push_addr;
    end else if (pop) begin
      lvl_d[0] = lvl_q[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    lvl_q[0] <= lvl_d[0];
    lvl_q[1] <= lvl_d[1];
  end

  assign top = lvl_q[0];
  assign second = lvl_q[1];
endmodule

// [pcs_core.sv]
// Program counter and two-level call stack sequencer
//
// Function
// - Counter steps by one each cycle unless the instruction loads it.
// - Absolute jump loads all nine counter bits from the address field.
// - Low counter byte register reads and writes counter bits 7:0.
// - Call or low byte write loads bits 7:0, forces bit 8 to zero.
// - Move, add or bit-set targeting the low byte act as low byte writes.
// - Any reset sets the counter to all ones, the last program word.
// - After the last word executes, the counter wraps to zero.
// - Return stack has exactly two levels, 8 or 9 bits wide.
// - Call copies level one to two, then stores counter plus one.
// - Beyond two nested calls, older return addresses are dropped.
// - Return loads counter from level one, then copies two into one.
// - Repeated returns keep returning to the level-two address.
// - Return with literal loads the accumulator with its literal.
// - No overflow or underflow status is provided.
// - Stack changes only through calls and returns, never push or pop.
`include "pcs_map.svh"
module pcs_core #(
  parameter int STACK_W = `PCS_PC_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pcs_pkg::pcs_cmd_s cmd,
  output logic [`PCS_PC_W-1:0] pc,
  output logic [`PCS_LOW_W-1:0] counter_low_byte,
  output logic acc_load,
  output logic [`PCS_LIT_W-1:0] acc_value
);
  // ========================================
  // Parameter check
  // Only the two documented memory variants make sense
  if (STACK_W != `PCS_LOW_W && STACK_W != `PCS_PC_W) begin : g_bad_width
    $error("STACK_W must be 8 or 9");
  end

  // ========================================
  // Helpers
  function automatic logic [`PCS_PC_W-1:0] low_target(input logic [`PCS_LOW_W-1:0] v);
    low_target = {1'b0, v};
  endfunction

  // Call and low byte writes share the bit-8 clear
  function automatic logic is_low_load(input pcs_pkg::pcs_op_e op);
    is_low_load = (op == pcs_pkg::PCS_OP_CALL) || (op == pcs_pkg::PCS_OP_LOW_WRITE);
  endfunction

  function automatic logic [`PCS_PC_W-1:0] widen(input logic [STACK_W-1:0] v);
    logic [`PCS_PC_W-1:0] w;
    w = '0;
    w[STACK_W-1:0] = v;
    widen = w;
  endfunction

  // ========================================
  // Stack
  logic push;
  logic pop;
  logic [`PCS_PC_W-1:0] ret_addr;
  logic [STACK_W-1:0] stk_top;
  logic [STACK_W-1:0] stk_second;

  assign push = (cmd.op == pcs_pkg::PCS_OP_CALL) && !rst;
  assign pop = (cmd.op == pcs_pkg::PCS_OP_RETURN) && !rst;
  assign ret_addr = pc + `PCS_PC_ONE;

  pcs_ret_stack #(
    .ADDR_W(STACK_W)
  ) u_stack (
    .sys_clk(sys_clk),
    .push(push),
    .pop(pop),
    .push_addr(ret_addr[STACK_W-1:0]),
    .top(stk_top),
    .second(stk_second)
  );

  // ========================================
  // Counter and accumulator load
  logic [`PCS_PC_W-1:0] pc_d;
  logic [`PCS_PC_W-1:0] pc_q;
  logic acc_load_d;
  logic acc_load_q;
  logic [`PCS_LIT_W-1:0] acc_d;
  logic [`PCS_LIT_W-1:0] acc_q;

  // No overflow flag by design: old entries just fall off
  always_comb begin
    pc_d = pc_q + `PCS_PC_ONE;
    unique case (cmd.op)
      pcs_pkg::PCS_OP_STEP: begin
      end
      pcs_pkg::PCS_OP_JUMP: begin
        pc_d = cmd.target;
      end
      pcs_pkg::PCS_OP_CALL: begin
        pc_d = low_target(cmd.target[`PCS_LOW_W-1:0]);
      end
      pcs_pkg::PCS_OP_LOW_WRITE: begin
        pc_d = low_target(cmd.target[`PCS_LOW_W-1:0]);
      end
      pcs_pkg::PCS_OP_RETURN: begin
        pc_d = widen(stk_top);
      end
      default: begin
      end
    endcase
    if (rst) begin
      pc_d = `PCS_PC_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    pc_q <= pc_d;
  end

  // Literal handed to the accumulator on a return
  always_comb begin
    acc_load_d = 1'b0;
    acc_d = acc_q;
    if (cmd.op == pcs_pkg::PCS_OP_RETURN) begin
      acc_load_d = 1'b1;
      acc_d = cmd.literal;
    end
    if (rst) begin
      acc_load_d = 1'b0;
      acc_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    acc_load_q <= acc_load_d;
    acc_q <= acc_d;
  end

  assign pc = pc_q;
  assign counter_low_byte = pc_q[7:0];
  assign acc_load = acc_load_q;
  assign acc_value = acc_q;

  // ========================================
  // Checks
  sequence s_call;
    cmd.op == pcs_pkg::PCS_OP_CALL;
  endsequence

  sequence s_return;
    cmd.op == pcs_pkg::PCS_OP_RETURN;
  endsequence

  property p_step;
    @(posedge sys_clk) disable iff (rst)
      cmd.op == pcs_pkg::PCS_OP_STEP |=> pc == $past(pc) + `PCS_PC_ONE;
  endproperty

  pc_step_a: assert property (p_step) else $error("counter did not step");

  jump_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd.op == pcs_pkg::PCS_OP_JUMP |=> pc == $past(cmd.target))
    else $error("jump target not loaded");

  low_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    is_low_load(cmd.op)
    |=> !pc[`PCS_HIGH_BIT] && pc[`PCS_LOW_W-1:0] == $past(cmd.target[`PCS_LOW_W-1:0]))
    else $error("low write did not clear bit 8");

  low_map_a: assert property (@(posedge sys_clk)
    counter_low_byte == pc[7:0]) else $error("low byte not mapped");

  reset_pc_a: assert property (@(posedge sys_clk)
    rst |=> pc == `PCS_PC_RESET) else $error("reset did not set counter");

  wrap_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    pc == `PCS_PC_RESET && cmd.op == pcs_pkg::PCS_OP_STEP |=> pc == `PCS_PC_ZERO)
    else $error("counter did not wrap");

  call_ret_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_call ##1 s_return |=> pc == $past(pc, 2) + `PCS_PC_ONE)
    else $error("return address wrong");

  nest_ret_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_call ##1 s_call ##1 s_call ##1 s_return ##1 s_return
    |=> pc == $past(pc, 4) + `PCS_PC_ONE)
    else $error("older call not kept");

  repeat_ret_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_return ##1 s_return ##1 s_return |=> pc == $past(pc))
    else $error("level two not kept");

  acc_ret_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_return |=> acc_load && acc_value == $past(cmd.literal))
    else $error("accumulator literal missing");

  // ========================================
  // Reference stack for the checks
  // Built from pc alone, so a fault inside the stack module still shows
  logic [`PCS_PC_W-1:0] chk_next;
  logic [`PCS_PC_W-1:0] chk_push;
  logic [`PCS_PC_W-1:0] chk_top_d;
  logic [`PCS_PC_W-1:0] chk_top_q;
  logic [`PCS_PC_W-1:0] chk_sec_d;
  logic [`PCS_PC_W-1:0] chk_sec_q;
  logic chk_top_ok_d;
  logic chk_top_ok_q;
  logic chk_sec_ok_d;
  logic chk_sec_ok_q;

  // Validity drops on reset though the levels survive: a safe undercount
  always_comb begin
    chk_next = pc + `PCS_PC_ONE;
    chk_push = widen(chk_next[STACK_W-1:0]);
    chk_top_d = chk_top_q;
    chk_sec_d = chk_sec_q;
    chk_top_ok_d = chk_top_ok_q;
    chk_sec_ok_d = chk_sec_ok_q;
    if (cmd.op == pcs_pkg::PCS_OP_CALL) begin
      chk_sec_d = chk_top_q;
      chk_sec_ok_d = chk_top_ok_q;
      chk_top_d = chk_push;
      chk_top_ok_d = 1'b1;
    end else if (cmd.op == pcs_pkg::PCS_OP_RETURN) begin
      chk_top_d = chk_sec_q;
      chk_top_ok_d = chk_sec_ok_q;
    end
    if (rst) begin
      chk_top_ok_d = 1'b0;
      chk_sec_ok_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    chk_top_q <= chk_top_d;
    chk_sec_q <= chk_sec_d;
    chk_top_ok_q <= chk_top_ok_d;
    chk_sec_ok_q <= chk_sec_ok_d;
  end

  sequence s_quiet;
    cmd.op != pcs_pkg::PCS_OP_CALL && cmd.op != pcs_pkg::PCS_OP_RETURN;
  endsequence

  sequence s_step;
    cmd.op == pcs_pkg::PCS_OP_STEP;
  endsequence

  sequence s_jump;
    cmd.op == pcs_pkg::PCS_OP_JUMP;
  endsequence

  sequence s_low_write;
    cmd.op == pcs_pkg::PCS_OP_LOW_WRITE;
  endsequence

  call_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_call |=> widen(stk_top) == $past(chk_push))
    else $error("call pushed wrong address");

  call_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_call ##0 chk_top_ok_q |=> stk_second == $past(stk_top))
    else $error("level one not copied down");

  ret_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_return ##0 chk_sec_ok_q |=> stk_top == $past(stk_second))
    else $error("level two not copied up");

  ret_ref_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_return ##0 chk_top_ok_q |=> pc == $past(chk_top_q))
    else $error("return went to wrong address");

  top_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_quiet ##0 chk_top_ok_q |=> stk_top == $past(stk_top))
    else $error("level one changed without call");

  second_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_quiet ##0 chk_sec_ok_q |=> stk_second == $past(stk_second))
    else $error("level two changed without call");

  acc_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_quiet |=> !acc_load)
    else $error("accumulator load without return");

  acc_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_quiet |=> acc_value == $past(acc_value))
    else $error("accumulator value changed");

  reset_acc_a: assert property (@(posedge sys_clk)
    rst |=> !acc_load && acc_value == '0)
    else $error("reset left accumulator load");

  reset_low_a: assert property (@(posedge sys_clk)
    rst |=> counter_low_byte == '1)
    else $error("low byte not all ones after reset");

  low_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_step ##0 pc == `PCS_PC_RESET |=> counter_low_byte == '0)
    else $error("low byte did not wrap");

  low_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_low_write |=> pc == {1'b0, $past(cmd.target[`PCS_LOW_W-1:0])})
    else $error("low byte write wrong");

  jump_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_jump |=> pc[`PCS_HIGH_BIT] == $past(cmd.target[`PCS_HIGH_BIT]))
    else $error("jump lost bit 8");
endmodule

// [pcs_dec_model.sv]
// Behavioural decoder model that feeds commands to the sequencer
module pcs_dec_model (
  input wire logic sys_clk,
  output pcs_pkg::pcs_cmd_s cmd
);
  // ==========================================
  // Command drive
  initial cmd = '{pcs_pkg::PCS_OP_STEP, 9'h000, 8'h00};
  // Held as a level until the next issue; the sequencer takes it each edge
  task automatic issue(input pcs_pkg::pcs_op_e op, input logic [8:0] t,
                       input logic [7:0] l);
    cmd = '{op, t, l};
  endtask
endmodule

// [pcs_core_tb.sv]
// Self-checking bench for the program counter and call stack
module pcs_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic rst;
  pcs_pkg::pcs_cmd_s cmd;
  logic [8:0] pc;
  logic [7:0] counter_low_byte;
  logic acc_load;
  logic [7:0] acc_value;
  int fail_count;
  int num_checks;
  pcs_core dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .cmd(cmd),
    .pc(pc),
    .counter_low_byte(counter_low_byte),
    .acc_load(acc_load),
    .acc_value(acc_value)
  );
  pcs_dec_model dec_u (.sys_clk(sys_clk), .cmd(cmd));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Shared helpers
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs change on the falling edge only; results read just past the rise
  task automatic run(input pcs_pkg::pcs_op_e op, input logic [8:0] t,
                     input logic [7:0] l);
    @(negedge sys_clk);
    rst = 1'b0;
    dec_u.issue(op, t, l);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic reset_wrap();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    check(pc, 9'h1FF);
    check({8'h00, acc_load}, 9'h000);
    run(pcs_pkg::PCS_OP_STEP, 9'h000, 8'h00);
    check(pc, 9'h000);
    run(pcs_pkg::PCS_OP_STEP, 9'h000, 8'h00);
    check(pc, 9'h001);
  endtask
  task automatic jump_low();
    run(pcs_pkg::PCS_OP_JUMP, 9'h1F0, 8'h00);
    check(pc, 9'h1F0);
    run(pcs_pkg::PCS_OP_LOW_WRITE, 9'h1A5, 8'h00);
    check(pc, 9'h0A5);
    check({1'b0, counter_low_byte}, 9'h0A5);
    run(pcs_pkg::PCS_OP_STEP, 9'h000, 8'h00);
    check({1'b0, counter_low_byte}, 9'h0A6);
  endtask
  // Three nested calls drop the oldest; returns then drain past empty
  task automatic stack_nest();
    run(pcs_pkg::PCS_OP_JUMP, 9'h010, 8'h00);
    run(pcs_pkg::PCS_OP_CALL, 9'h120, 8'h00);
    check(pc, 9'h020);
    run(pcs_pkg::PCS_OP_CALL, 9'h030, 8'h00);
    run(pcs_pkg::PCS_OP_CALL, 9'h040, 8'h00);
    check(pc, 9'h040);
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'hA5);
    check(pc, 9'h031);
    check({acc_load, acc_value}, 9'h1A5);
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'h3C);
    check(pc, 9'h021);
    check({acc_load, acc_value}, 9'h13C);
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'h00);
    check(pc, 9'h021);
    run(pcs_pkg::PCS_OP_STEP, 9'h000, 8'h00);
    check(pc, 9'h022);
    check({8'h00, acc_load}, 9'h000);
  endtask
  // Call then return back to back, then a return across unrelated loads
  task automatic call_return();
    run(pcs_pkg::PCS_OP_JUMP, 9'h005, 8'h00);
    run(pcs_pkg::PCS_OP_CALL, 9'h1AA, 8'h00);
    check(pc, 9'h0AA);
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'h5A);
    check(pc, 9'h006);
    check({acc_load, acc_value}, 9'h15A);
    run(pcs_pkg::PCS_OP_CALL, 9'h050, 8'h00);
    run(pcs_pkg::PCS_OP_LOW_WRITE, 9'h1C3, 8'h00);
    check(pc, 9'h0C3);
    run(pcs_pkg::PCS_OP_JUMP, 9'h1FE, 8'h00);
    check(pc, 9'h1FE);
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'h00);
    check(pc, 9'h007);
  endtask
  task automatic reset_keeps_stack();
    reset_wrap();
    run(pcs_pkg::PCS_OP_RETURN, 9'h000, 8'h77);
    check(pc, 9'h021);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    fail_count = 0;
    num_checks = 0;
    reset_wrap();
    jump_low();
    stack_nest();
    call_return();
    reset_keeps_stack();
    tally_and_finish();
  end
  // About 40 cycles are needed; a wide margin still ends a hang quickly
  initial begin
    repeat (2000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
